// ===== common/dcc_defs.vh
// Register map, field positions and reset values of the dual comparator control block
`ifndef DCC_DEFS_VH
`define DCC_DEFS_VH

// ==========================================================
// Register offsets (byte addresses on the plain port)
`define DCC_ADDR_W        4
`define DCC_CTRL0_ADDR    4'h0
`define DCC_CTRL1_ADDR    4'h4
`define DCC_IRQ_ADDR      4'h8
`define DCC_IEN_ADDR      4'hc

// ==========================================================
// Control register fields
`define DCC_ON_BIT        6
`define DCC_INV_BIT       5
`define DCC_RES_BIT       4
`define DCC_HYS_BIT       0
`define DCC_CTRL_RESET    8'h01
`define DCC_CTRL_WMASK    8'h61
`define DCC_HYS_RESET     2'h3

// ==========================================================
// Flag and enable registers: bit n belongs to comparator n
`define DCC_FLAG_RESET    2'h0
`define DCC_IEN_RESET     2'h0

// ==========================================================
// Timing counts
// Cycles a freshly enabled channel is held low: covers the enable output flop,
// the analog response and the synchroniser with its agreement stage
`define DCC_SETTLE_CYCLES 3'h6

`endif

// ===== design/dcc_sync.v
// Three-stage synchroniser with agreement filter for one asynchronous level
`timescale 1ns/1ps

module dcc_sync (
  // Clock and reset
  input  wire clock_i,
  input  wire rst_i,
  // Asynchronous level in, filtered level out
  input  wire async_i,
  output reg  level_o
);

  reg s1_r;
  reg s2_r;
  reg s3_r;

  // ==========================================================
  // Chain and filter: the level moves only when stages 2 and 3 agree
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_r <= async_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        level_o <= s3_r;
      end
    end
  end

endmodule // dcc_sync

// ===== design/dcc_top.v
// Dual comparator control: registers, result polarity, change flags, wake and pin routing
//
// Notes on behaviour
// - Bit 6 switches each comparator on
// - Disabled comparator forces its result low
// - Bit 5 inverts the raw comparison
// - Bit 4 reads the polarised result only
// - Uninverted result is one when positive exceeds negative
// - Bit 0 enables hysteresis, resets to one
// - Bits 7 and 3..1 read zero, ignore writes
// - Any result change sets that channel's flag
// - Flag follows internal result, not the pin
// - Flag and enable request that channel's vector
// - Change during sleep with comparator on wakes
// - Flag high at sleep entry blocks wake
// - Enabled comparator drops its input pull-highs
// - Result can drive the shared output pin
// - Two fully independent channels
`timescale 1ns/1ps
`include "dcc_defs.vh"

module dcc_top (
  // Clock and reset
  input  wire                    clock_i,
  input  wire                    rst_i,
  // Register port
  input  wire [`DCC_ADDR_W-1:0]  addr_i,
  input  wire [7:0]              wdata_i,
  input  wire                    wr_i,
  input  wire                    rd_i,
  output reg  [7:0]              rdata_o,
  // Analog comparator cores
  input  wire [1:0]              raw_cmp_i,
  output reg  [1:0]              comparator_on_o,
  output reg  [1:0]              hysteresis_on_o,
  output reg  [1:0]              pullhigh_off_o,
  // Shared output pins
  input  wire [1:0]              pin_sel_i,
  output reg  [1:0]              pin_out_o,
  output reg  [1:0]              pin_oe_o,
  // Interrupt controller and power manager
  input  wire                    sleep_i,
  output reg  [1:0]              irq_vec_o,
  output reg  [1:0]              wake_o
);

  // Per-channel control state
  reg  [1:0] comparator_on_r;
  reg  [1:0] result_invert_r;
  reg  [1:0] hysteresis_on_r;
  reg  [1:0] compare_result_r;
  reg  [1:0] flag_r;
  reg  [1:0] ien_r;
  reg  [1:0] wake_block_r;
  reg        sleep_d_r;
  reg  [2:0] settle0_r;
  reg  [2:0] settle1_r;
  wire [1:0] cmp_sync;
  wire       sleep_s;

  // Control register image of one channel
  function [7:0] ctrl_image;
    input on;
    input inv;
    input res;
    input hys;
    begin
      ctrl_image = 8'h00;
      ctrl_image[`DCC_ON_BIT]  = on;
      ctrl_image[`DCC_INV_BIT] = inv;
      ctrl_image[`DCC_RES_BIT] = res;
      ctrl_image[`DCC_HYS_BIT] = hys;
    end
  endfunction

  // Next value of a settle counter: reload when the channel is switched on,
  // otherwise count down and rest at zero
  function [2:0] settle_next;
    input       start;
    input [2:0] count;
    begin
      if (start) begin
        settle_next = `DCC_SETTLE_CYCLES;
      end else if (count != 3'h0) begin
        settle_next = count - 3'h1;
      end else begin
        settle_next = 3'h0;
      end
    end
  endfunction

  // Strobe aimed at one register offset
  function reg_hit;
    input                   strobe;
    input [`DCC_ADDR_W-1:0] addr;
    input [`DCC_ADDR_W-1:0] target;
    begin
      reg_hit = strobe && (addr == target);
    end
  endfunction

  // Next state of one flag: a software write loads it, a result change sets it,
  // and the set wins when both fall in one cycle
  function flag_next;
    input wr;
    input wval;
    input flag;
    input change;
    begin
      if (wr) begin
        flag_next = wval | change;
      end else begin
        flag_next = flag | change;
      end
    end
  endfunction

  // Two per-channel bits at the bottom of a read byte, the rest zero
  function [7:0] pair_image;
    input [1:0] bits;
    begin
      pair_image = {6'h00, bits};
    end
  endfunction

  // ==========================================================
  // Synchronisers for the analog decisions and the sleep level
  // A level is adopted only when the last two stages agree, so a decision
  // caught mid-swing cannot reach the edge detector as a double change
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_sync
      dcc_sync u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .async_i (raw_cmp_i[g]),
        .level_o (cmp_sync[g])
      );
    end
  endgenerate

  // Sleep arrives from the power manager, outside this clock's timing
  dcc_sync u_sleep_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .async_i (sleep_i),
    .level_o (sleep_s)
  );

  // ==========================================================
  // Result bit and change-flag logic, one pass per channel
  wire [1:0] wr_ctrl;
  wire [1:0] switch_on;
  wire [1:0] settled;
  wire [1:0] result_nxt;
  wire [1:0] changed;
  wire [1:0] fresh_change;
  wire [1:0] wake_nxt;
  wire       wr_flag;
  wire       wr_ien;
  wire       sleep_entry;

  // Register decode; unmapped offsets match nothing and are ignored
  assign wr_ctrl[0]  = reg_hit(wr_i, addr_i, `DCC_CTRL0_ADDR);
  assign wr_ctrl[1]  = reg_hit(wr_i, addr_i, `DCC_CTRL1_ADDR);
  assign wr_flag     = reg_hit(wr_i, addr_i, `DCC_IRQ_ADDR);
  assign wr_ien      = reg_hit(wr_i, addr_i, `DCC_IEN_ADDR);
  assign sleep_entry = sleep_s && !sleep_d_r;

  // A channel going from off to on; its synchronised level is stale until
  // the fresh decision has crossed the synchroniser
  assign switch_on[0] = wr_ctrl[0] && wdata_i[`DCC_ON_BIT] && !comparator_on_r[0];
  assign switch_on[1] = wr_ctrl[1] && wdata_i[`DCC_ON_BIT] && !comparator_on_r[1];
  assign settled[0]   = (settle0_r == 3'h0);
  assign settled[1]   = (settle1_r == 3'h0);

  // Polarised result, low while the channel is off or still settling
  assign result_nxt = comparator_on_r & settled & (cmp_sync ^ result_invert_r);
  assign changed    = result_nxt ^ compare_result_r;

  // A change that raises a flag which was low; only that may wake the device
  assign fresh_change = changed & ~flag_r;
  assign wake_nxt     = {2{sleep_s}} & comparator_on_r & fresh_change & ~wake_block_r;

  // ==========================================================
  // Settle counters: a freshly enabled channel reads low until its decision
  // has crossed the synchroniser, so a stale level cannot raise a flag
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      settle0_r <= 3'h0;
      settle1_r <= 3'h0;
    end else begin
      settle0_r <= settle_next(switch_on[0], settle0_r);
      settle1_r <= settle_next(switch_on[1], settle1_r);
    end
  end

  // ==========================================================
  // Sleep entry: remember which flags were already high as sleep began
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sleep_d_r    <= 1'b0;
      wake_block_r <= 2'h0;
    end else begin
      sleep_d_r <= sleep_s;
      // Cleared again once the device is awake
      if (sleep_entry) begin
        wake_block_r <= flag_r;
      end else if (!sleep_s) begin
        wake_block_r <= 2'h0;
      end
    end
  end

  // ==========================================================
  // Control registers and result bits
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      comparator_on_r  <= 2'h0;
      result_invert_r  <= 2'h0;
      hysteresis_on_r  <= `DCC_HYS_RESET;
      compare_result_r <= 2'h0;
      ien_r            <= `DCC_IEN_RESET;
    end else begin
      compare_result_r <= result_nxt;
      if (wr_ctrl[0]) begin
        comparator_on_r[0] <= wdata_i[`DCC_ON_BIT];
        result_invert_r[0] <= wdata_i[`DCC_INV_BIT];
        hysteresis_on_r[0] <= wdata_i[`DCC_HYS_BIT];
      end
      if (wr_ctrl[1]) begin
        comparator_on_r[1] <= wdata_i[`DCC_ON_BIT];
        result_invert_r[1] <= wdata_i[`DCC_INV_BIT];
        hysteresis_on_r[1] <= wdata_i[`DCC_HYS_BIT];
      end
      if (wr_ien) begin
        ien_r <= wdata_i[1:0];
      end
    end
  end

  // ==========================================================
  // Flags: software writes any value, a change sets and wins over clear
  // Presetting a flag before sleep is how software suppresses a wake-up
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      flag_r <= `DCC_FLAG_RESET;
    end else begin
      flag_r[0] <= flag_next(wr_flag, wdata_i[0], flag_r[0], changed[0]);
      flag_r[1] <= flag_next(wr_flag, wdata_i[1], flag_r[1], changed[1]);
    end
  end

  // ==========================================================
  // Registered outputs
  // Every output is a flop, so the analog cores and the pins see clean levels
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      comparator_on_o <= 2'h0;
      hysteresis_on_o <= `DCC_HYS_RESET;
      pullhigh_off_o  <= 2'h0;
      pin_out_o       <= 2'h0;
      pin_oe_o        <= 2'h0;
      irq_vec_o       <= 2'h0;
      wake_o          <= 2'h0;
    end else begin
      comparator_on_o <= comparator_on_r;
      hysteresis_on_o <= hysteresis_on_r;
      pullhigh_off_o  <= comparator_on_r;
      // The pin carries the stored result bit; the flags never look at it
      pin_out_o       <= compare_result_r & pin_sel_i;
      pin_oe_o        <= pin_sel_i;
      irq_vec_o       <= flag_r & ien_r;
      // Wake on a fresh flag only, never from one already high at entry
      wake_o          <= wake_nxt;
    end
  end

  // ==========================================================
  // Read data, valid the cycle after the read strobe only
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      // The result bit reads low from the very cycle its channel is switched off
      case (addr_i)
        `DCC_CTRL0_ADDR: rdata_o <= ctrl_image(comparator_on_r[0], result_invert_r[0],
                                               compare_result_r[0] & comparator_on_r[0],
                                               hysteresis_on_r[0]);
        `DCC_CTRL1_ADDR: rdata_o <= ctrl_image(comparator_on_r[1], result_invert_r[1],
                                               compare_result_r[1] & comparator_on_r[1],
                                               hysteresis_on_r[1]);
        `DCC_IRQ_ADDR:   rdata_o <= pair_image(flag_r);
        `DCC_IEN_ADDR:   rdata_o <= pair_image(ien_r);
        default:         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

endmodule // dcc_top

// ===== verification/dcc_cmp_model.sv
// Behavioural model of the two analog comparator cores
`timescale 1ns/1ps
module dcc_cmp_model (
  // Clock, enables and analog levels
  input  wire       clock_i,
  input  wire [1:0] on_i,
  input  wire [7:0] p0_i, n0_i, p1_i, n1_i,
  // Raw decisions
  output wire [1:0] raw_o
);
  // An idle core gives no valid decision, so its output wanders
  reg wander_r = 1'b0;
  always @(posedge clock_i) wander_r <= ~wander_r;
  // Decisions arrive after an analog delay, off the clock edge
  assign #1.7 raw_o = {on_i[1] ? p1_i > n1_i : wander_r, on_i[0] ? p0_i > n0_i : ~wander_r};
endmodule // dcc_cmp_model

// ===== verification/dcc_top_monitor.sv
// Port assertions for the dual comparator control block
`timescale 1ns/1ps
module dcc_top_monitor (
  // All ports of the block, seen as inputs
  input wire       clock_i, rst_i, wr_i, rd_i, sleep_i,
  input wire [3:0] addr_i,
  input wire [7:0] wdata_i, rdata_o,
  input wire [1:0] raw_cmp_i, comparator_on_o, hysteresis_on_o, pullhigh_off_o,
  input wire [1:0] pin_sel_i, pin_out_o, pin_oe_o, irq_vec_o, wake_o
);
  // ==========
  // Register port and pin checks
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  wire rd_ctl = rd_i && !addr_i[3] && addr_i[1:0] == 2'h0;
  chk_read_idle: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata not idle");
  chk_unmapped_zero: assert property (rd_i && addr_i[1:0] != 2'h0 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_ctrl_unused: assert property (rd_ctl |=> (rdata_o & 8'h8e) == 8'h00)
    else $error("unused control bits set");
  chk_result_gated: assert property (rd_ctl |=> !rdata_o[4] || rdata_o[6])
    else $error("result high while off");
  chk_on_write: assert property (wr_i && addr_i == 4'h4 && wdata_i[6] |-> ##[1:2] comparator_on_o[1])
    else $error("enable write lost");
  chk_hys_write: assert property (wr_i && addr_i == 4'h0 && !wdata_i[0] |-> ##[1:2] !hysteresis_on_o[0])
    else $error("hysteresis write lost");
  chk_pull_match: assert property (pullhigh_off_o == comparator_on_o)
    else $error("pull-high state wrong");
  chk_pin_gate: assert property ((pin_out_o & ~pin_oe_o) == 2'h0)
    else $error("pin driven unselected");
  chk_oe_follow: assert property (pin_oe_o == $past(pin_sel_i))
    else $error("pin enable late");
  chk_wake_pulse: assert property (wake_o != 2'h0 |=> (wake_o & $past(wake_o)) == 2'h0)
    else $error("wake longer than one cycle");
  cover property (wake_o != 2'h0);
  cover property (irq_vec_o != 2'h0);
  cover property (rd_ctl ##1 rdata_o[4]);
endmodule // dcc_top_monitor
bind dcc_top dcc_top_monitor mon (.clock_i(clock_i), .rst_i(rst_i), .wr_i(wr_i), .rd_i(rd_i),
  .sleep_i(sleep_i), .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o),
  .raw_cmp_i(raw_cmp_i), .comparator_on_o(comparator_on_o), .hysteresis_on_o(hysteresis_on_o),
  .pullhigh_off_o(pullhigh_off_o), .pin_sel_i(pin_sel_i), .pin_out_o(pin_out_o),
  .pin_oe_o(pin_oe_o), .irq_vec_o(irq_vec_o), .wake_o(wake_o));

// ===== verification/dcc_top_test.sv
// Self-checking bench for the dual comparator control block
`timescale 1ns/1ps
module dcc_top_test;
  // ==========
  // Stimulus, expectations and design
  logic clock_i = 1'b0, rst_i = 1'b1, wr_i = 1'b0, rd_i = 1'b0, sleep_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00, rdata_o, p0 = 8'h00, n0 = 8'h00, p1 = 8'h00, n1 = 8'h00, d;
  logic [1:0] raw, on, hys, ph, pin_sel_i = 2'h0, pout, poe, irq, wake, flg = 2'h0, ien = 2'h0;
  logic [7:0] ctl [2];
  integer num_errors = 0, n_checks = 0, seed = 91092, cyc = 0, wakes = 0, i, op, w;
  dcc_top dut (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .raw_cmp_i(raw), .comparator_on_o(on),
    .hysteresis_on_o(hys), .pullhigh_off_o(ph), .pin_sel_i(pin_sel_i), .pin_out_o(pout),
    .pin_oe_o(poe), .sleep_i(sleep_i), .irq_vec_o(irq), .wake_o(wake));
  dcc_cmp_model ana (.clock_i(clock_i), .on_i(on), .p0_i(p0), .n0_i(n0), .p1_i(p1),
    .n1_i(n1), .raw_o(raw));
  initial forever #2 clock_i = ~clock_i;
  // Cycle ceiling and wake pulse count
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    wakes <= wakes + wake[0] + wake[1];
    if (cyc == 6000) begin
      num_errors = num_errors + 1;
      results;
    end
  end
  function automatic logic res(input integer c);
    res = ctl[c][6] & ((c ? p1 > n1 : p0 > n0) ^ ctl[c][5]);
  endfunction
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input integer k);
    repeat (k) @(posedge clock_i);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i) begin wr_i <= 1'b1; addr_i <= a; wdata_i <= v; end
    @(posedge clock_i) wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clock_i) begin rd_i <= 1'b1; addr_i <= a; end
    @(posedge clock_i) rd_i <= 1'b0;
    #1 check(nm, rdata_o, e);
  endtask
  // Control write (c below 2) or analog change, tracking expected flags
  task automatic upd(input integer c, input logic [7:0] v, input logic [31:0] a);
    logic [1:0] r;
    r = {res(1), res(0)};
    if (c < 2) begin wr({1'b0, c[0], 2'h0}, v); ctl[c] = v & 8'h61; end
    else @(negedge clock_i) {p0, n0, p1, n1} = a;
    flg = flg | (r ^ {res(1), res(0)});
    wt(8);
  endtask
  task automatic chk_all;
    rd(4'h0, ctl[0] | {3'h0, res(0), 4'h0}, "ctrl0");
    rd(4'h4, ctl[1] | {3'h0, res(1), 4'h0}, "ctrl1");
    rd(4'h8, {6'h0, flg}, "flags");
    check("irq", {6'h0, irq}, {6'h0, flg & ien});
    check("on", {4'h0, on, hys}, {4'h0, ctl[1][6], ctl[0][6], ctl[1][0], ctl[0][0]});
    check("pin", {2'h0, ph, poe, pout},
      {2'h0, ctl[1][6], ctl[0][6], pin_sel_i, pin_sel_i & {res(1), res(0)}});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial begin
    ctl[0] = 8'h01;
    ctl[1] = 8'h01;
    wt(8);
    rst_i <= 1'b0;
    wr(4'h6, 8'hff);
    rd(4'h2, 8'h00, "unmapped");
    chk_all;
    upd(0, 8'hff, 0);
    upd(1, 8'h9e, 0);
    chk_all;
    $display("test reset and corners done");
    for (i = 0; i < 60; i++) begin
      op = {$random(seed)} % 5;
      d = $random(seed);
      if (op < 3) upd(op, d, $random(seed));
      else if (op == 3) begin wr(4'h8, d); flg = d[1:0]; end
      else begin wr(4'hc, d); ien = d[1:0]; @(posedge clock_i) pin_sel_i <= d[3:2]; end
      wt(4);
      chk_all;
    end
    $display("test random done");
    upd(0, 8'h40, 0);
    upd(1, 8'h00, 0);
    upd(2, 0, 32'h10200000);
    wr(4'h8, 8'h00);
    flg = 2'h0;
    for (i = 0; i < 2; i++) begin
      @(posedge clock_i) sleep_i <= 1'b1;
      wt(8);
      w = wakes;
      upd(2, 0, i ? 32'h05200000 : 32'h30200000);
      check("wake", 8'(wakes - w), i ? 8'h00 : 8'h01);
      @(posedge clock_i) sleep_i <= 1'b0;
      wr(4'h8, 8'h01);
      wt(8);
    end
    chk_all;
    $display("test sleep wake done");
    results;
  end
endmodule // dcc_top_test
